//--- verilog/enc_pkg.sv
/*
  constants, register map and carriers for the angle encoder and commutation outputs.
  assumes one 250 mhz clock and 14-bit angle samples.
*/
package enc_pkg;

  localparam int CLK_PERIOD_NS    = 4;
  localparam int SAMPLE_PERIOD_NS = 1000;
  localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SLEW_STEP_NS     = 125;

  localparam int ANGLE_W = 14;
  localparam int POS_W   = 13;

  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] OUTCFG_OFFSET = 8'h04;
  localparam logic [7:0] HYST_OFFSET   = 8'h08;
  localparam logic [7:0] WARN_OFFSET   = 8'h0c;
  localparam logic [7:0] MASK_OFFSET   = 8'h10;
  localparam logic [7:0] STATE_OFFSET  = 8'h14;

  localparam int ENC_INV_BIT   = 0;
  localparam int ROT_REV_BIT   = 1;
  localparam int COMM_MODE_BIT = 2;
  localparam int IDX_W_LSB     = 4;
  localparam int GRAN_LSB      = 0;
  localparam int ROUTE_BIT     = 12;
  localparam int SLEW_LSB      = 16;
  localparam int HYST_LSB      = 12;
  localparam int WARN_SLEW_BIT = 0;
  localparam int WARN_ZERO_BIT = 1;
  localparam int STAT_POS_LSB  = 0;
  localparam int STAT_DIR_BIT  = 16;
  localparam int STAT_ABI_LSB  = 20;
  localparam int STAT_UVW_LSB  = 24;

  localparam logic [5:0] SLEW_RESET  = 6'h08;
  localparam logic [3:0] GRAN_RESET  = 4'h3;
  localparam logic [5:0] HYST_RESET  = 6'h00;
  localparam logic [1:0] IDX_W_RESET = 2'h0;

  localparam logic [3:0] RES_MIN = 4'h3;
  localparam logic [3:0] RES_MAX = 4'he;

  localparam logic [13:0] HALF_TURN      = 14'h2000;
  localparam logic [13:0] THIRD_TURN     = 14'h1555;
  localparam logic [13:0] TWO_THIRD_TURN = 14'h2aab;

  typedef struct packed {
    logic a;
    logic b;
    logic index;
  } abi_s;

  typedef struct packed {
    logic u;
    logic v;
    logic w;
  } uvw_s;

endpackage

//--- verilog/uvw_sector.sv
/*
  three-phase commutation pattern from a mechanical angle and a pole-pair count.
  assumes a 14-bit angle, one full turn spanning the whole code range.
*/
`timescale 1ns/1ns
module uvw_sector
  import enc_pkg::*;
(
  input  wire logic [13:0] angle,
  input  wire logic [3:0]  pairs_m1,
  output enc_pkg::uvw_s    phases
);

  wire logic [17:0] scaled;
  wire logic [13:0] elec;
  wire logic [13:0] elec_v;
  wire logic [13:0] elec_w;

  // electrical angle repeats pairs_m1+1 times per turn
  assign scaled = 18'(angle) * (18'(pairs_m1) + 18'h1);
  assign elec   = scaled[13:0];

  // each phase high for half a cycle, a third of a cycle apart
  assign elec_v   = elec - THIRD_TURN;
  assign elec_w   = elec - TWO_THIRD_TURN;
  assign phases.u = elec < HALF_TURN;
  assign phases.v = elec_v < HALF_TURN;
  assign phases.w = elec_w < HALF_TURN;

endmodule

//--- verilog/encoder_commutation_outputs.sv
/*
  quadrature a/b/index and u/v/w commutation output stage with an ahb-lite register slave.
  assumes angle_in is a 14-bit shaft angle synchronous to hclk, a single zero-wait slave.
*/
`timescale 1ns/1ns
module encoder_commutation_outputs
  import enc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic [13:0] angle_in,
  output enc_pkg::abi_s    abi_out,
  output enc_pkg::uvw_s    uvw_out,
  output logic             irq
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // register state
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] rdata_reg;
  logic        enc_inv_reg;
  logic        rot_rev_reg;
  logic        comm_reg;
  logic [1:0]  idx_w_reg;
  logic [3:0]  gran_reg;
  logic        route_reg;
  logic [5:0]  slew_reg;
  logic [5:0]  hyst_reg;
  logic [1:0]  warn_reg;
  logic [1:0]  warn_next;
  logic [1:0]  mask_reg;

  // datapath state
  logic [7:0]  smp_cnt_reg;
  logic        first_reg;
  logic [13:0] ang_reg;
  logic [13:0] hang_reg;
  logic        hdir_reg;
  logic [12:0] pos_reg;
  logic [12:0] pos_next;
  logic [10:0] slew_cnt_reg;
  abi_s        abi_reg;
  uvw_s        uvw_reg;

  wire logic        addr_phase;
  wire logic [31:0] rd_data;
  wire logic [31:0] state_word;
  wire logic        sample_tick;
  wire logic [13:0] ang_dir;
  wire logic [13:0] hdiff;
  wire logic [13:0] hfwd;
  wire logic [13:0] hback;
  wire logic        h_adv;
  wire logic        h_flip;
  wire logic [13:0] proc_ang;
  wire logic [3:0]  res;
  wire logic [3:0]  shift;
  wire logic [12:0] qmask;
  wire logic [12:0] qhalf;
  wire logic [12:0] target;
  wire logic [12:0] delta;
  wire logic        lag;
  wire logic        up;
  wire logic        slew_on;
  wire logic [10:0] slew_cycles;
  wire logic        slew_ready;
  wire logic        step;
  wire logic        slew_evt;
  wire logic        zero_evt;
  wire logic [2:0]  idx_width;
  wire abi_s        abi_raw;
  wire uvw_s        uvw_raw;

  // ahb-lite slave, zero wait states, always okay
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = rdata_reg;
  assign addr_phase = hsel && htrans[1] && hready;
  // a read in a write's data phase still returns the register's old value

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg   <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_reg <= addr_phase && hwrite;
      if (addr_phase)
        wr_addr_reg <= haddr[7:0];
      if (addr_phase && !hwrite)
        rdata_reg <= rd_data;
    end
  end

  wire logic wr_ctrl   = wr_pend_reg && hit(wr_addr_reg, CTRL_OFFSET);
  wire logic wr_outcfg = wr_pend_reg && hit(wr_addr_reg, OUTCFG_OFFSET);
  wire logic wr_hyst   = wr_pend_reg && hit(wr_addr_reg, HYST_OFFSET);
  wire logic wr_warn   = wr_pend_reg && hit(wr_addr_reg, WARN_OFFSET);
  wire logic wr_mask   = wr_pend_reg && hit(wr_addr_reg, MASK_OFFSET);

  assign state_word = (32'(pos_reg) << STAT_POS_LSB)
                    | (32'(hdir_reg) << STAT_DIR_BIT)
                    | (32'(abi_reg) << STAT_ABI_LSB)
                    | (32'(uvw_reg) << STAT_UVW_LSB);

  // unmapped addresses read as zero
  assign rd_data =
      hit(haddr[7:0], CTRL_OFFSET)   ? ((32'(enc_inv_reg) << ENC_INV_BIT)
                                      | (32'(rot_rev_reg) << ROT_REV_BIT)
                                      | (32'(comm_reg) << COMM_MODE_BIT)
                                      | (32'(idx_w_reg) << IDX_W_LSB)) :
      hit(haddr[7:0], OUTCFG_OFFSET) ? ((32'(gran_reg) << GRAN_LSB)
                                      | (32'(route_reg) << ROUTE_BIT)
                                      | (32'(slew_reg) << SLEW_LSB)) :
      hit(haddr[7:0], HYST_OFFSET)   ? (32'(hyst_reg) << HYST_LSB) :
      hit(haddr[7:0], WARN_OFFSET)   ? 32'(warn_reg) :
      hit(haddr[7:0], MASK_OFFSET)   ? 32'(mask_reg) :
      hit(haddr[7:0], STATE_OFFSET)  ? state_word : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      enc_inv_reg <= 1'b0;
      rot_rev_reg <= 1'b0;
      comm_reg    <= 1'b0;
      idx_w_reg   <= IDX_W_RESET;
      gran_reg    <= GRAN_RESET;
      route_reg   <= 1'b0;
      slew_reg    <= SLEW_RESET;
      hyst_reg    <= HYST_RESET;
      mask_reg    <= 2'h0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        enc_inv_reg <= hwdata[ENC_INV_BIT];
        rot_rev_reg <= hwdata[ROT_REV_BIT];
        comm_reg    <= hwdata[COMM_MODE_BIT];
        idx_w_reg   <= hwdata[IDX_W_LSB +: 2];
      end
      if (wr_outcfg)
      begin
        gran_reg  <= hwdata[GRAN_LSB +: 4];
        route_reg <= hwdata[ROUTE_BIT];
        slew_reg  <= hwdata[SLEW_LSB +: 6];
      end
      if (wr_hyst)
        hyst_reg <= hwdata[HYST_LSB +: 6];
      if (wr_mask)
        mask_reg <= hwdata[1:0];
    end
  end

  // warning flags: write one to clear, a new event wins over the clear
  assign warn_next = (warn_reg & ~(wr_warn ? hwdata[1:0] : 2'h0))
                   | ({1'b0, slew_evt} << WARN_SLEW_BIT)
                   | ({1'b0, zero_evt} << WARN_ZERO_BIT);
  assign irq       = |(warn_reg & mask_reg);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      warn_reg <= 2'h0;
    else
      warn_reg <= warn_next;
  end

  // angle sample strobe every microsecond
  assign sample_tick = smp_cnt_reg == 8'(SAMPLE_CYCLES - 1);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      smp_cnt_reg <= 8'h00;
    else
      smp_cnt_reg <= sample_tick ? 8'h00 : smp_cnt_reg + 8'h01;
  end

  // reverse mirrors the angle so it decreases
  assign ang_dir = rot_rev_reg ? 14'(~angle_in + 14'h1) : angle_in;

  // hysteresis: follow forward motion, flip head once window is left
  // direction resets to increasing, window starts behind the first sample
  assign hdiff  = ang_dir - hang_reg;
  assign hfwd   = hdir_reg ? 14'(~hdiff + 14'h1) : hdiff;
  assign hback  = 14'(~hfwd + 14'h1);
  assign h_adv  = !hfwd[13] && (hfwd != 14'h0000);
  assign h_flip = hfwd[13] && (hback > 14'(hyst_reg));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      first_reg <= 1'b1;
      ang_reg   <= 14'h0000;
      hang_reg  <= 14'h0000;
      hdir_reg  <= 1'b0;
    end
    else if (sample_tick)
    begin
      first_reg <= 1'b0;
      ang_reg   <= ang_dir;
      if (first_reg || h_adv)
        hang_reg <= ang_dir;
      else if (h_flip)
      begin
        hang_reg <= ang_dir;
        hdir_reg <= ~hdir_reg;
      end
    end
  end

  assign proc_ang = route_reg ? hang_reg : ang_reg;

  // quadrature position at the selected resolution; out of range clamps
  assign res    = (gran_reg < RES_MIN) ? RES_MIN :
                  (gran_reg > RES_MAX) ? RES_MAX : gran_reg;
  assign shift  = res - 4'h2;
  assign qmask  = 13'h1fff >> (res - RES_MIN);
  assign qhalf  = qmask ^ (qmask >> 1);
  assign target = 13'(proc_ang >> shift) & qmask;
  assign delta  = (target - pos_reg) & qmask;
  assign lag    = delta != 13'h0000;
  assign up     = (delta & qhalf) == 13'h0000;

  // slew period (n+1)*0.125 us, rounded up to whole clocks
  assign slew_on     = slew_reg != 6'h00;
  assign slew_cycles = 11'(((int'(slew_reg) + 1) * SLEW_STEP_NS + CLK_PERIOD_NS - 1)
                           / CLK_PERIOD_NS);
  assign slew_ready  = slew_cnt_reg >= slew_cycles;
  assign step        = slew_on && lag && slew_ready;
  assign slew_evt    = slew_on && lag && !slew_ready;

  // one quadrature state per step, so gray order is kept while catching up
  always_comb
  begin
    pos_next = pos_reg;
    if (!slew_on)
      pos_next = target;
    else if (step && up)
      pos_next = (pos_reg + 13'h0001) & qmask;
    else if (step)
      pos_next = (pos_reg - 13'h0001) & qmask;
  end

  assign zero_evt = (pos_next == 13'h0000) && (pos_reg != 13'h0000);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pos_reg      <= 13'h0000;
      slew_cnt_reg <= 11'h000;
    end
    else
    begin
      pos_reg <= pos_next;
      // timer counts up from reset, so the first step may wait one slew period
      if (step)
        slew_cnt_reg <= 11'h001;
      else if (!slew_ready)
        slew_cnt_reg <= slew_cnt_reg + 11'h001;
    end
  end

  // states 0..3 map to ab 00, 01, 11, 10
  assign abi_raw.a = pos_reg[1];
  assign abi_raw.b = pos_reg[1] ^ pos_reg[0];

  // index covers quadrature states 0..width-1: entered at zero going up,
  // left at zero going down
  assign idx_width     = 3'(idx_w_reg) + 3'h1;
  assign abi_raw.index = pos_reg < 13'(idx_width);

  uvw_sector u_uvw_sector
  (
    .angle    (proc_ang),
    .pairs_m1 (gran_reg),
    .phases   (uvw_raw)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      abi_reg <= '0;
      uvw_reg <= '0;
    end
    else
    begin
      abi_reg <= comm_reg ? 3'h0 : (abi_raw ^ {3{enc_inv_reg}});
      uvw_reg <= comm_reg ? (uvw_raw ^ {3{enc_inv_reg}}) : 3'h0;
    end
  end

  assign abi_out = abi_reg;
  assign uvw_out = uvw_reg;

endmodule

//--- dv/enc_properties.sv
/*
  port-level checker for the encoder output stage.
  assumes it is bound into encoder_commutation_outputs and sees only its ports.
*/
`timescale 1ns/1ns
module enc_properties
  import enc_pkg::*;
(
  input wire logic     hclk,
  input wire logic     hresetn,
  input wire logic     hsel,
  input wire logic [1:0] htrans,
  input wire logic     hwrite,
  input wire logic     hready,
  input wire logic     hreadyout,
  input wire logic     hresp,
  input enc_pkg::abi_s abi_out,
  input enc_pkg::uvw_s uvw_out,
  input wire logic     irq
);
  logic       wr_dp;
  logic [8:0] since_wr;
  logic       quiet;
  // config writes may move outputs at once, so the a/b, index and exclusivity checks wait for a quiet spell
  assign quiet = since_wr > 9'h12c;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_dp    <= 1'b0;
      since_wr <= 9'h000;
    end
    else
    begin
      wr_dp    <= hsel & htrans[1] & hready & hwrite;
      since_wr <= wr_dp ? 9'h000 : since_wr + {8'h00, since_wr != 9'h1ff};
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_ab_step;
    quiet && $changed({abi_out.a, abi_out.b});
  endsequence
  sequence s_ab_hold;
    $stable({abi_out.a, abi_out.b})[*8];
  endsequence
  property p_gray;
    s_ab_step |-> $stable(abi_out.a) || $stable(abi_out.b);
  endproperty
  a_gray: assert property (p_gray) else $error("a and b moved together");
  property p_space;
    s_ab_step |=> s_ab_hold;
  endproperty
  a_space: assert property (p_space) else $error("a/b edges too close");
  property p_idx;
    quiet && $changed(abi_out.index) |-> $changed({abi_out.a, abi_out.b});
  endproperty
  a_idx: assert property (p_idx) else $error("index edge off a state edge");
  property p_uvw;
    uvw_out != 3'h7;
  endproperty
  a_uvw: assert property (p_uvw) else $error("u, v and w all high");
  property p_excl;
    quiet |-> abi_out == 3'h0 || uvw_out == 3'h0;
  endproperty
  a_excl: assert property (p_excl) else $error("both output kinds active");
  property p_irq;
    $fell(irq) |-> $past(wr_dp);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt dropped without a write");
  property p_reset;
    $rose(hresetn) |-> abi_out == 3'h0 && uvw_out == 3'h0 && !irq;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs active after reset");
  property p_bus;
    hreadyout && !hresp;
  endproperty
  a_bus: assert property (p_bus) else $error("bus not ready or not okay");
endmodule

bind encoder_commutation_outputs enc_properties chk_i (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .abi_out(abi_out), .uvw_out(uvw_out), .irq(irq));

//--- dv/quad_rx.sv
/*
  quadrature receiver model: counts a/b states, flags illegal moves, times edges.
  assumes a/b are sampled on the same clock that drives them.
*/
`timescale 1ns/1ns
module quad_rx
  import enc_pkg::*;
(
  input wire logic     hclk,
  input wire logic     hresetn,
  input enc_pkg::abi_s line_in,
  output int           count,
  output int           bad,
  output int           gap
);
  logic [1:0] st_reg;
  logic [1:0] d;
  int         since;
  // gray state to phase number, so a step of +1 or -1 is one legal move
  assign d = {line_in.a, line_in.a ^ line_in.b} - {st_reg[1], st_reg[1] ^ st_reg[0]};
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg <= 2'h0;
      count  <= 0;
      bad    <= 0;
      since  <= 0;
    end
    else
    begin
      since <= since + 1;
      if ({line_in.a, line_in.b} != st_reg)
      begin
        st_reg <= {line_in.a, line_in.b};
        since  <= 1;
        gap    <= since;
        if (d == 2'h1)
          count <= count + 1;
        else if (d == 2'h3)
          count <= count - 1;
        else
          bad <= bad + 1;
      end
    end
  end
endmodule

//--- dv/tb_top.sv
/*
  self-checking bench for the encoder output stage.
  assumes a 250 mhz clock, one zero-wait ahb-lite slave and the receiver model.
*/
`timescale 1ns/1ns
module tb_top;
  import enc_pkg::*;
  typedef struct packed { logic [7:0] a; logic [31:0] v; } row_s;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hready;
  logic [31:0] hrdata;
  logic [13:0] angle_in = 14'h0;
  abi_s        abi_out;
  uvw_s        uvw_out;
  logic        irq;
  logic [31:0] d;
  int          rx_cnt, rx_bad, rx_gap, n_errors, cmp_count;
  row_s rows[7] = '{'{CTRL_OFFSET, 32'h0}, '{OUTCFG_OFFSET, {10'h0, SLEW_RESET, 12'h0, GRAN_RESET}},
    '{HYST_OFFSET, 32'h0}, '{WARN_OFFSET, 32'h0}, '{MASK_OFFSET, 32'h0},
    '{STATE_OFFSET, 32'h0010_0000}, '{8'h18, 32'h0}};
  always #2 hclk = ~hclk;
  encoder_commutation_outputs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(), .angle_in(angle_in), .abi_out(abi_out),
    .uvw_out(uvw_out), .irq(irq));
  quad_rx rx (.hclk(hclk), .hresetn(hresetn), .line_in(abi_out), .count(rx_cnt), .bad(rx_bad),
    .gap(rx_gap));
  task automatic end_of_test();
    $display("errors %0d, compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ap(input logic [7:0] a, input logic w);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    ap(a, 1'b1);
    hwdata <= v;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a);
    ap(a, 1'b0);
    do @(posedge hclk); while (hready !== 1'b1);
    d = hrdata;
  endtask
  task automatic samp();
    repeat (260) @(posedge hclk);
  endtask
  task automatic go(input logic [13:0] a, input int c);
    int i;
    @(posedge hclk);
    angle_in <= a;
    for (i = 0; i < 2000 && rx_cnt != c; i++) @(posedge hclk);
    @(negedge hclk);
    chk("position", rx_cnt, c);
  endtask
  function automatic logic [2:0] uvw_exp(input logic [13:0] a, input logic [3:0] k);
    logic [13:0] e;
    e = a * ({1'b0, k} + 5'h01);
    return {e < HALF_TURN, e - THIRD_TURN < HALF_TURN, e - TWO_THIRD_TURN < HALF_TURN};
  endfunction
  initial
  begin
    #200000;
    n_errors++;
    end_of_test();
  end
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i])
    begin
      rd(rows[i].a);
      chk("register", d, rows[i].v);
    end
    samp();
    go(14'h0006, 3);
    chk("step gap", rx_gap, (9 * SLEW_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    rd(WARN_OFFSET);
    chk("slew warning", 32'(d[WARN_SLEW_BIT]), 32'h1);
    wr(MASK_OFFSET, 32'h1);
    @(negedge hclk);
    chk("irq", 32'(irq), 32'h1);
    wr(WARN_OFFSET, 32'h1);
    @(negedge hclk);
    chk("irq", 32'(irq), 32'h0);
    wr(MASK_OFFSET, 32'h0);
    go(14'h0000, 0);
    chk("index", 32'(abi_out.index), 32'h1);
    wr(CTRL_OFFSET, 32'h30);
    go(14'h0006, 3);
    chk("index", 32'(abi_out.index), 32'h1);
    go(14'h0008, 4);
    chk("index", 32'(abi_out.index), 32'h0);
    go(14'h0000, 0);
    wr(CTRL_OFFSET, 32'h02);
    go(14'h0004, -2);
    chk("index", 32'(abi_out.index), 32'h0);
    go(14'h0000, 0);
    wr(CTRL_OFFSET, 32'h0);
    wr(OUTCFG_OFFSET, 32'h3);
    wr(WARN_OFFSET, 32'h1);
    go(14'h0002, 1);
    rd(WARN_OFFSET);
    chk("slew warning", 32'(d[WARN_SLEW_BIT]), 32'h0);
    chk("illegal moves", rx_bad, 0);
    wr(CTRL_OFFSET, 32'h1);
    samp();
    chk("abi", 32'(abi_out), 32'h5);
    chk("uvw", 32'(uvw_out), 32'h0);
    wr(CTRL_OFFSET, 32'h4);
    @(posedge hclk);
    angle_in <= 14'h0a00;
    for (int k = 0; k < 16; k++)
    begin
      wr(OUTCFG_OFFSET, 32'(k));
      samp();
      chk("uvw", 32'(uvw_out), 32'(uvw_exp(14'h0a00, 4'(k))));
      chk("abi", 32'(abi_out), 32'h0);
    end
    wr(CTRL_OFFSET, 32'h5);
    samp();
    chk("uvw", 32'(uvw_out), 32'(uvw_exp(14'h0a00, 4'hf) ^ 3'h7));
    // reset in mid-run: outputs drop at once, registers return to defaults
    @(posedge hclk);
    hresetn  <= 1'b0;
    angle_in <= 14'h0000;
    @(negedge hclk);
    chk("abi in reset", 32'(abi_out), 32'h0);
    chk("uvw in reset", 32'(uvw_out), 32'h0);
    chk("irq in reset", 32'(irq), 32'h0);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i])
    begin
      rd(rows[i].a);
      chk("register", d, rows[i].v);
    end
    // hysteresis routed, window of 8 codes, fastest slew
    wr(OUTCFG_OFFSET, 32'h0001_1003);
    wr(HYST_OFFSET, 32'h0000_8000);
    go(14'h0010, 8);
    @(posedge hclk);
    angle_in <= 14'h000c;
    samp();
    chk("hysteresis hold", rx_cnt, 8);
    go(14'h0006, 3);
    rd(STATE_OFFSET);
    chk("direction", 32'(d[STAT_DIR_BIT]), 32'h1);
    go(14'h0000, 0);
    // coarsest resolution: a quarter turn is one quadrature state
    wr(OUTCFG_OFFSET, 32'h0000_000e);
    go(14'h1000, 1);
    end_of_test();
  end
endmodule
